// ==== hdl/dcf_pkg.sv ====
// dcf_pkg: constants and carrier types for the clip / float abs / float add unit
// assumes one core clock; issue pipeline presents one operation per cycle
package dcf_pkg;
   // operation select
   typedef enum logic [1:0] {
      DCF_OP_CLIP,
      DCF_OP_ABS,
      DCF_OP_ABSFLAGS,
      DCF_OP_ADD
   } dcf_op_t;

   // exception bit positions in the status word and flag vectors
   localparam int DCF_BIT_DBZ = 0;
   localparam int DCF_BIT_INX = 1;
   localparam int DCF_BIT_UNF = 2;
   localparam int DCF_BIT_OVF = 3;
   localparam int DCF_BIT_INV = 4;
   localparam int DCF_BIT_IFZ = 5;
   localparam int DCF_BIT_OFZ = 6;
   localparam int DCF_FLAG_W  = 7;

   // rounding modes
   localparam logic [1:0] DCF_RND_NEAREST = 2'h0;
   localparam logic [1:0] DCF_RND_ZERO    = 2'h1;
   localparam logic [1:0] DCF_RND_POS     = 2'h2;
   localparam logic [1:0] DCF_RND_NEG     = 2'h3;

   // special encodings
   localparam logic [31:0] DCF_QNAN     = 32'hFFFFFFFF;
   localparam logic [31:0] DCF_POS_INF  = 32'h7F800000;
   localparam logic [31:0] DCF_ZERO     = 32'h00000000;
   localparam logic [7:0]  DCF_EXP_MAX  = 8'hFF;
   localparam logic [31:0] DCF_RESET_RESULT = 32'h00000000;
   localparam logic [6:0]  DCF_RESET_FLAGS  = 7'h00;

   // operation request from the issue stage
   typedef struct packed {
      logic        valid;
      dcf_op_t     op;
      logic        guard;
      logic [31:0] first_source;
      logic [31:0] second_source;
   } dcf_req_t;

   // writeback to the register file
   typedef struct packed {
      logic        write;
      logic [31:0] data;
   } dcf_wb_t;
endpackage : dcf_pkg

// ==== hdl/dcf_unit.sv ====
// dcf_unit: dual 16-bit clip, float abs, float abs flag probe, float add
// assumes the issue stage drives one request per cycle; result one cycle later
`timescale 1ns/1ps
module dcf_unit
   import dcf_pkg::*;
(
   // clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             rst_n_i,
   // operation request
   input  wire dcf_req_t         req_i,
   // flag updates from other float units in the same cycle
   input  wire logic [6:0]       ext_flags_i,
   // explicit status-word write
   input  wire logic             status_write_i,
   input  wire logic [6:0]       status_wdata_i,
   input  wire logic [1:0]       round_mode_i,
   // writeback and status
   output dcf_wb_t               wb_o,
   output logic [6:0]            program_status_word_o
);

   // fields of a single float
   function automatic logic is_denorm(input logic [31:0] f);
      is_denorm = (f[30:23] == 8'h00) && (f[22:0] != 23'h0);
   endfunction : is_denorm

   function automatic logic is_nan(input logic [31:0] f);
      is_nan = (f[30:23] == DCF_EXP_MAX) && (f[22:0] != 23'h0);
   endfunction : is_nan

   function automatic logic is_inf(input logic [31:0] f);
      is_inf = (f[30:23] == DCF_EXP_MAX) && (f[22:0] == 23'h0);
   endfunction : is_inf

   function automatic logic is_snan(input logic [31:0] f);
      is_snan = is_nan(f) && !f[22];
   endfunction : is_snan

   // mantissa with hidden bit and three guard bits
   function automatic logic [26:0] ext_mant(input logic [31:0] f);
      ext_mant = {(f[30:23] != 8'h00), f[22:0], 3'b000};
   endfunction : ext_mant

   // align the smaller mantissa, shifted-out bits folded into a sticky lsb
   function automatic logic [26:0] align_small(input logic [26:0] m, input logic [7:0] sh);
      logic [26:0] shifted;
      logic        lost;
      if (sh > 8'd26)
      begin
         shifted = 27'h0;
         lost = (m != 27'h0);
      end
      else
      begin
         shifted = m >> sh;
         lost = ((shifted << sh) != m);
      end
      align_small = {shifted[26:1], shifted[0] | lost};
   endfunction : align_small

   // leading zeros from the hidden-bit position down; stops at the first one
   function automatic logic [4:0] lead_zeros(input logic [26:0] m);
      logic found;
      found = 1'b0;
      lead_zeros = 5'd0;
      for (int i = 26; i >= 0; i--)
      begin
         if (m[i] && !found)
         begin
            lead_zeros = 5'(26 - i);
            found = 1'b1;
         end
      end
   endfunction : lead_zeros

   // round-up decision under the status rounding mode
   function automatic logic round_incr(input logic [1:0] mode, input logic rb, input logic sb, input logic lsb,
                                       input logic neg);
      unique case (mode)
         DCF_RND_NEAREST: round_incr = rb & (sb | lsb);
         DCF_RND_ZERO:    round_incr = 1'b0;
         DCF_RND_POS:     round_incr = (rb | sb) & ~neg;
         DCF_RND_NEG:     round_incr = (rb | sb) & neg;
      endcase
   endfunction : round_incr

   // exact zero sum: -0 for two negatives, or cancellation rounding down
   function automatic logic [31:0] zero_sum(input logic [1:0] mode, input logic sub, input logic sa,
                                            input logic sb);
      if (sub)
         zero_sum = {(mode == DCF_RND_NEG), 31'h0};
      else
         zero_sum = {sa & sb, 31'h0};
   endfunction : zero_sum

   function automatic logic [15:0] clip_half(input logic [15:0] v, input logic [15:0] bound);
      if (v[15])
         clip_half = 16'h0000;
      else if (v > bound)
         clip_half = bound;
      else
         clip_half = v;
   endfunction : clip_half

   // dual clip
   // bound is the low half only; upper bits of the second source are ignored
   logic [31:0] clip_res;
   always_comb
   begin
      clip_res = {clip_half(req_i.first_source[31:16], req_i.second_source[15:0]),
                  clip_half(req_i.first_source[15:0], req_i.second_source[15:0])};
   end

   // absolute value and its flags
   logic [31:0] abs_res;
   logic [6:0]  abs_flags;
   always_comb
   begin
      abs_flags = 7'h00;
      if (is_denorm(req_i.first_source))
      begin
         abs_res = DCF_ZERO;
         abs_flags[DCF_BIT_IFZ] = 1'b1;
      end
      else if (is_nan(req_i.first_source))
      begin
         abs_res = DCF_QNAN;
         abs_flags[DCF_BIT_INV] = is_snan(req_i.first_source);
      end
      else
         abs_res = {1'b0, req_i.first_source[30:0]};
   end

   // float add: operand unpack with input flush
   // flushed operands keep their sign so -0 + -0 stays -0
   logic [31:0] opa;
   logic [31:0] opb;
   logic        in_flush;
   always_comb
   begin
      in_flush = is_denorm(req_i.first_source) | is_denorm(req_i.second_source);
      opa = is_denorm(req_i.first_source) ? {req_i.first_source[31], 31'h0} : req_i.first_source;
      opb = is_denorm(req_i.second_source) ? {req_i.second_source[31], 31'h0} : req_i.second_source;
   end

   // magnitude-ordered operands: big and small
   logic [31:0] big;
   logic [31:0] sml;
   logic [26:0] mb;
   logic [26:0] ms;
   logic [26:0] ms_sh;
   logic [7:0]  ediff;
   logic        eff_sub;
   logic [27:0] msum;
   always_comb
   begin
      if (opa[30:0] >= opb[30:0])
      begin
         big = opa;
         sml = opb;
      end
      else
      begin
         big = opb;
         sml = opa;
      end
      mb = ext_mant(big);
      ms = ext_mant(sml);
      ediff = big[30:23] - sml[30:23];
      ms_sh = align_small(ms, ediff);
      eff_sub = big[31] ^ sml[31];
      msum = eff_sub ? ({1'b0, mb} - {1'b0, ms_sh}) : ({1'b0, mb} + {1'b0, ms_sh});
   end

   // normalise, round, classify
   logic [31:0] add_res;
   logic [6:0]  add_flags;
   logic [27:0] norm;
   logic [9:0]  exp_n;
   logic [4:0]  lz;
   logic [24:0] mant_r;
   logic        rbit;
   logic        sbit;
   logic        inexact;
   logic        rnd_up;
   logic        res_sign;
   always_comb
   begin
      add_flags = 7'h00;
      add_flags[DCF_BIT_IFZ] = in_flush;
      res_sign = big[31];
      norm = msum;
      exp_n = {2'b00, big[30:23]};
      lz = 5'd0;
      mant_r = 25'h0;
      rbit = 1'b0;
      sbit = 1'b0;
      inexact = 1'b0;
      rnd_up = 1'b0;
      add_res = DCF_ZERO;
      if (is_nan(opa) || is_nan(opb))
      begin
         add_res = DCF_QNAN;
         add_flags[DCF_BIT_INV] = is_snan(opa) | is_snan(opb);
      end
      else if (is_inf(opa) && is_inf(opb) && (opa[31] != opb[31]))
      begin
         add_res = DCF_QNAN;
         add_flags[DCF_BIT_INV] = 1'b1;
      end
      else if (is_inf(big))
         add_res = big;
      else if (msum == 28'h0)
         add_res = zero_sum(round_mode_i, eff_sub, opa[31], opb[31]);
      else
      begin
         // a carry out shifts right once, otherwise shift left to the hidden bit
         if (msum[27])
         begin
            norm = {1'b0, msum[27:2], msum[1] | msum[0]};
            exp_n = exp_n + 10'd1;
         end
         else
         begin
            lz = lead_zeros(msum[26:0]);
            norm = msum << lz;
            exp_n = exp_n - {5'b00000, lz};
         end
         mant_r = {1'b0, norm[26:3]};
         rbit = norm[2];
         sbit = norm[1] | norm[0];
         inexact = rbit | sbit;
         // round before the range checks so a carry into the exponent is seen
         rnd_up = round_incr(round_mode_i, rbit, sbit, mant_r[0], res_sign);
         mant_r = mant_r + {24'h0, rnd_up};
         if (mant_r[24])
            exp_n = exp_n + 10'd1;
         // tiny results flush to a signed zero, no denormal leaves the unit
         if (exp_n[9] || exp_n == 10'd0)
         begin
            add_res = {res_sign, 31'h0};
            add_flags[DCF_BIT_OFZ] = 1'b1;
            add_flags[DCF_BIT_UNF] = 1'b1;
            add_flags[DCF_BIT_INX] = 1'b1;
         end
         else if (exp_n >= 10'd255)
         begin
            // overflow saturates to +inf whatever the sign and rounding mode
            add_res = DCF_POS_INF;
            add_flags[DCF_BIT_OVF] = 1'b1;
            add_flags[DCF_BIT_INX] = 1'b1;
         end
         else
         begin
            add_res = {res_sign, exp_n[7:0], mant_r[24] ? mant_r[23:1] : mant_r[22:0]};
            add_flags[DCF_BIT_INX] = inexact;
         end
      end
   end

   // result and flag selection
   dcf_wb_t     next_wb;
   logic [6:0]  own_flags;
   always_comb
   begin
      next_wb.write = req_i.valid & req_i.guard;
      own_flags = 7'h00;
      unique case (req_i.op)
         DCF_OP_CLIP:     next_wb.data = clip_res;
         DCF_OP_ABS:
         begin
            next_wb.data = abs_res;
            own_flags = abs_flags;
         end
         DCF_OP_ABSFLAGS: next_wb.data = {25'h0, abs_flags};
         DCF_OP_ADD:
         begin
            next_wb.data = add_res;
            own_flags = add_flags;
         end
      endcase
      // a false guard drops this operation's flag updates as well
      if (!next_wb.write)
         own_flags = 7'h00;
   end

   // explicit write replaces the flags; fresh updates are ORed in either way
   logic [6:0]  next_psw;
   always_comb
   begin
      if (status_write_i)
         next_psw = status_wdata_i;
      else
         next_psw = program_status_word_o;
      next_psw = next_psw | own_flags | ext_flags_i;
   end

   // writeback register
   // data holds the last written result, so a false guard shows no change
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wb_o.write <= 1'b0;
         wb_o.data  <= DCF_RESET_RESULT;
      end
      else
      begin
         wb_o.write <= next_wb.write;
         if (next_wb.write)
            wb_o.data <= next_wb.data;
      end
   end

   // sticky status flags, set beats clear
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         program_status_word_o <= DCF_RESET_FLAGS;
      else
         program_status_word_o <= next_psw;
   end

endmodule : dcf_unit

// ==== testbench/dcf_unit_assertions.sv ====
// dcf_unit_assertions: port-level checks of dcf_unit
// assumes one core clock; bound onto every dcf_unit instance
`timescale 1ns/1ps
module dcf_unit_assertions
   import dcf_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   // watched ports
   input  wire dcf_req_t   req_i,
   input  wire logic [6:0] ext_flags_i,
   input  wire logic       status_write_i,
   input  wire logic [6:0] status_wdata_i,
   input  wire dcf_wb_t    wb_o,
   input  wire logic [6:0] program_status_word_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   guard_write_a: assert property (req_i.valid && req_i.guard |=> wb_o.write)
      else $error("guarded op not written");
   false_guard_a: assert property ((!req_i.valid || !req_i.guard) && !status_write_i && ext_flags_i == 7'h00
      |=> $stable(program_status_word_o) && $stable(wb_o.data)) else $error("idle or false guard changed state");
   probe_psw_a: assert property (req_i.valid && req_i.op == DCF_OP_ABSFLAGS && !status_write_i
      && ext_flags_i == 7'h00 |=> $stable(program_status_word_o)) else $error("probe touched status");
   sticky_flags_a: assert property (!status_write_i
      |=> (program_status_word_o & $past(program_status_word_o)) == $past(program_status_word_o))
      else $error("status flag cleared");
   ext_merge_a: assert property (!status_write_i
      |=> (program_status_word_o & $past(ext_flags_i)) == $past(ext_flags_i)) else $error("flag update lost");
   status_load_a: assert property (status_write_i && !req_i.valid && ext_flags_i == 7'h00
      |=> program_status_word_o == $past(status_wdata_i)) else $error("status write not loaded");
   abs_mag_a: assert property (req_i.valid && req_i.guard && req_i.op == DCF_OP_ABS
      && req_i.first_source[30:23] != 8'h00 && req_i.first_source[30:23] != DCF_EXP_MAX
      |=> wb_o.data == ($past(req_i.first_source) & 32'h7FFFFFFF)) else $error("abs magnitude wrong");
   abs_flush_a: assert property (req_i.valid && req_i.guard && req_i.op == DCF_OP_ABS
      && req_i.first_source[30:23] == 8'h00 && req_i.first_source[22:0] != 23'h0
      |=> wb_o.data == DCF_ZERO && program_status_word_o[DCF_BIT_IFZ]) else $error("abs denormal not flushed");
   probe_vec_a: assert property (req_i.valid && req_i.guard && req_i.op == DCF_OP_ABSFLAGS
      && req_i.first_source[30:23] == 8'h00 && req_i.first_source[22:0] != 23'h0
      |=> wb_o.data == (32'h1 << DCF_BIT_IFZ)) else $error("probe vector wrong");
   inf_cancel_a: assert property (req_i.valid && req_i.guard && req_i.op == DCF_OP_ADD
      && req_i.first_source == DCF_POS_INF && req_i.second_source == (DCF_POS_INF | 32'h80000000)
      |=> wb_o.data == DCF_QNAN && program_status_word_o[DCF_BIT_INV]) else $error("infinity cancel wrong");
   no_write_a: assert property (!(req_i.valid && req_i.guard) |=> !wb_o.write)
      else $error("write without guarded op");
endmodule : dcf_unit_assertions

bind dcf_unit dcf_unit_assertions u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
   .ext_flags_i(ext_flags_i), .status_write_i(status_write_i), .status_wdata_i(status_wdata_i),
   .wb_o(wb_o), .program_status_word_o(program_status_word_o));

// ==== testbench/dcf_wb_model.sv ====
// dcf_wb_model: destination register on the writeback side
// assumes wb_i comes straight from dcf_unit
`timescale 1ns/1ps
module dcf_wb_model
   import dcf_pkg::*;
(
   // clock and reset
   input  wire logic    sys_clk_i,
   input  wire logic    rst_n_i,
   // writeback in, register out
   input  wire dcf_wb_t wb_i,
   output logic [31:0]  dest_o
);
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         dest_o <= DCF_RESET_RESULT;
      else if (wb_i.write)
         dest_o <= wb_i.data;
   end
endmodule : dcf_wb_model

// ==== testbench/testbench.sv ====
// testbench: directed checks of dcf_unit through its ports
// assumes the checker binds itself onto dcf_unit
`timescale 1ns/1ps
module testbench
   import dcf_pkg::*;
;
   logic        sys_clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   dcf_req_t    req = '0;
   dcf_op_t     op_sel = DCF_OP_CLIP;
   logic [6:0]  ext = 7'h0;
   logic        st_wr = 1'b0;
   logic [6:0]  st_wdata = 7'h0;
   logic [1:0]  rmode = DCF_RND_NEAREST;
   dcf_wb_t     wb;
   logic [6:0]  psw;
   logic [31:0] dest;
   logic [31:0] last = 32'h0;
   int          miscompares = 0;
   int          cmp_count = 0;

   always #2 sys_clk_i = ~sys_clk_i;

   dcf_unit u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req), .ext_flags_i(ext),
      .status_write_i(st_wr), .status_wdata_i(st_wdata), .round_mode_i(rmode), .wb_o(wb),
      .program_status_word_o(psw));
   dcf_wb_model u_wb (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_i(wb), .dest_o(dest));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // optional status clear, one op with side flag updates, then result checks
   task automatic run(input logic g, input logic [31:0] a, input logic [31:0] b, input logic [31:0] ed,
                      input logic [6:0] ef, input logic [6:0] ex, input logic clr);
      @(posedge sys_clk_i);
      st_wr <= clr;
      @(posedge sys_clk_i);
      st_wr <= 1'b0;
      req   <= '{1'b1, op_sel, g, a, b};
      ext   <= ex;
      @(posedge sys_clk_i);
      req.valid <= 1'b0;
      ext       <= 7'h0;
      #1;
      if (g)
         last = ed;
      chk({31'h0, wb.write}, {31'h0, g});
      chk(wb.data, last);
      chk({25'h0, psw}, {25'h0, ef});
      @(posedge sys_clk_i);
      #1;
      chk(dest, last);
      chk({31'h0, wb.write}, 32'h0);
   endtask : run

   task automatic set_mode(input logic [1:0] m);
      @(posedge sys_clk_i);
      rmode <= m;
   endtask : set_mode

   // explicit status write, then a write of zero beside a flag update: the update wins
   task automatic t_status();
      @(posedge sys_clk_i);
      st_wr    <= 1'b1;
      st_wdata <= 7'h41;
      @(posedge sys_clk_i);
      st_wdata <= 7'h00;
      ext      <= 7'h04;
      #1;
      chk({25'h0, psw}, 32'h00000041);
      @(posedge sys_clk_i);
      st_wr <= 1'b0;
      ext   <= 7'h00;
      #1;
      chk({25'h0, psw}, 32'h00000004);
      @(posedge sys_clk_i);
      #1;
      chk({25'h0, psw}, 32'h00000004);
   endtask : t_status

   task automatic t_clip();
      op_sel = DCF_OP_CLIP;
      run(1'b1, 32'h00800080, 32'h0000007F, 32'h007F007F, 7'h0, 7'h0, 1'b1);
      run(1'b1, 32'h12345678, 32'h00000ABC, 32'h0ABC0ABC, 7'h0, 7'h0, 1'b1);
      run(1'b1, 32'h800003FE, 32'h000003FF, 32'h000003FE, 7'h0, 7'h0, 1'b1);
      run(1'b0, 32'h7FFF7FFF, 32'h00007FFE, 32'h0, 7'h0, 7'h0, 1'b1);
      run(1'b1, 32'h7FFF8000, 32'h0000FFFF, 32'h7FFF0000, 7'h0, 7'h0, 1'b1);
   endtask : t_clip

   task automatic t_abs();
      op_sel = DCF_OP_ABS;
      run(1'b1, 32'hBF800000, 32'h0, 32'h3F800000, 7'h0, 7'h0, 1'b1);
      run(1'b1, 32'hFFBFFFFF, 32'h0, DCF_QNAN, 7'h10, 7'h0, 1'b1);
      run(1'b1, 32'hFFFFFFFF, 32'h0, DCF_QNAN, 7'h00, 7'h0, 1'b1);
      run(1'b1, 32'h00400000, 32'h0, 32'h0, 7'h20, 7'h0, 1'b1);
      run(1'b0, 32'hFF7FFFFF, 32'h0, 32'h0, 7'h20, 7'h0, 1'b0);
      op_sel = DCF_OP_ABSFLAGS;
      run(1'b1, 32'h00400000, 32'h0, 32'h00000020, 7'h0, 7'h0, 1'b1);
      run(1'b1, 32'hBF800000, 32'h0, 32'h0, 7'h0, 7'h0, 1'b1);
      run(1'b1, 32'hFFBFFFFF, 32'h0, 32'h00000010, 7'h0, 7'h0, 1'b1);
   endtask : t_abs

   task automatic t_add();
      op_sel = DCF_OP_ADD;
      run(1'b1, 32'hC0400000, 32'h3F800000, 32'hC0000000, 7'h0, 7'h0, 1'b1);
      run(1'b1, 32'h7F7FFFFF, 32'h7F7FFFFF, DCF_POS_INF, 7'h0A, 7'h0, 1'b1);
      run(1'b1, 32'h7F800000, 32'hFF800000, DCF_QNAN, 7'h10, 7'h0, 1'b1);
      run(1'b1, 32'h00C00000, 32'h80800000, 32'h0, 7'h46, 7'h0, 1'b1);
      run(1'b1, 32'h40400000, 32'h00400000, 32'h40400000, 7'h20, 7'h0, 1'b1);
      run(1'b1, 32'h40400000, 32'h00800000, 32'h40400000, 7'h02, 7'h0, 1'b1);
      set_mode(DCF_RND_POS);
      run(1'b1, 32'h40400000, 32'h00800000, 32'h40400001, 7'h02, 7'h0, 1'b1);
      set_mode(DCF_RND_ZERO);
      run(1'b1, 32'h40400000, 32'h00800000, 32'h40400000, 7'h02, 7'h0, 1'b1);
      set_mode(DCF_RND_NEG);
      run(1'b1, 32'hC0400000, 32'h80800000, 32'hC0400001, 7'h02, 7'h0, 1'b1);
      run(1'b1, 32'h40400000, 32'hC0400000, 32'h80000000, 7'h00, 7'h0, 1'b1);
      set_mode(DCF_RND_NEAREST);
      run(1'b1, 32'h40400000, 32'hC0400000, 32'h00000000, 7'h00, 7'h0, 1'b1);
      run(1'b0, 32'h7F7FFFFF, 32'h7F7FFFFF, 32'h0, 7'h01, 7'h01, 1'b1);
      run(1'b1, 32'h40400000, 32'h00800000, 32'h40400000, 7'h0B, 7'h08, 1'b0);
   endtask : t_add

   task automatic give_verdict();
      if (miscompares == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   initial
   begin
      repeat (4) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      t_clip();
      t_abs();
      t_add();
      t_status();
      give_verdict();
   end
endmodule : testbench
